// ===== core/afl_pkg.sv
// Constants, register layouts and state types of the front-end link block.
// Assumes a 32-bit AHB-Lite register bus and a single 50 MHz system clock.
`default_nettype none
package afl_pkg;

   // Register byte addresses on the bus
   localparam logic [7:0] ADDR_MAIN = 8'h00;   // Main configuration
   localparam logic [7:0] ADDR_CTL  = 8'h04;   // Front-end control
   localparam logic [7:0] ADDR_ADR  = 8'h08;   // Front-end address
   localparam logic [7:0] ADDR_STAT = 8'h0C;   // Front-end status
   localparam logic [7:0] ADDR_IRQ  = 8'h10;   // Interrupt status
   localparam logic [7:0] ADDR_MASK = 8'h14;   // Interrupt mask
   localparam logic [7:0] ADDR_RXD  = 8'h18;   // Last decimated sample

   // Main configuration bit positions
   localparam int MAIN_ROLE_BIT = 0;          // 1: central office unit
   localparam int MAIN_ACT_BIT  = 1;          // Write 1: activation request

   // Serial control word shape
   localparam int FRAME_BITS = 16;            // Bits per transaction
   localparam int ADDR_BITS  = 7;             // Front-end register number
   localparam int DATA_BITS  = 8;             // Data byte
   localparam logic RW_READ  = 1'b1;          // Direction bit for a read
   localparam logic [3:0] LAST_BIT = 4'hF;    // Index of final bit period

   // Front-end register numbers and values used by the sequencer
   localparam logic [6:0] FE_SPEC_REG = 7'h01; // Spectrum select register
   localparam logic [6:0] FE_GAIN_REG = 7'h02; // Receive gain register
   localparam logic [7:0] SPEC_DN_VAL = 8'h01; // Downstream filter
   localparam logic [7:0] SPEC_UP_VAL = 8'h00; // Upstream filter

   // Gain: eight codes, +3 dB down to -18 dB in 3 dB steps
   localparam int GAIN_CODES = 8;
   localparam int GAIN_W     = $clog2(GAIN_CODES);

   // Interrupt bits
   localparam int IRQ_XFER = 0;               // Serial transfer done
   localparam int IRQ_ACT  = 1;               // Activation done
   localparam int IRQ_W    = 2;

   // Link bus widths
   localparam int DAC_W = 4;
   localparam int ADC_W = 6;
   localparam int ACC_W = 16;                 // Decimator accumulator

   // Front-end control register layout
   typedef struct packed {
      logic [GAIN_W-1:0]    gain;             // Receive gain code
      logic                 spec_dn;          // 1: downstream spectrum
      logic [DATA_BITS-1:0] wdata;            // Data for software writes
   } afl_ctl_t;
   localparam int CTL_W = $bits(afl_ctl_t);

   // Front-end address register layout
   typedef struct packed {
      logic                 rd;               // Direction, 1 = read
      logic [ADDR_BITS-1:0] addr;             // Front-end register number
   } afl_adr_t;
   localparam int ADR_W = $bits(afl_adr_t);

   // Front-end status register layout
   typedef struct packed {
      logic                 done;             // Last transfer complete
      logic                 busy;             // Transfer in progress
      logic [DATA_BITS-1:0] rdata;            // Data of last read
   } afl_stat_t;

   // Serial engine states
   typedef enum logic [2:0] {
      SER_IDLE  = 3'b001,
      SER_ARM   = 3'b010,
      SER_SHIFT = 3'b100
   } afl_ser_t;

   // Activation sequencer states
   typedef enum logic [1:0] {
      ACT_IDLE = 2'b01,
      ACT_RUN  = 2'b10
   } afl_act_t;

   // Whole state of the block
   typedef struct packed {
      logic                  ref_s1, ref_s2, ref_s3;
      logic                  in_s1, in_s2;
      logic [ADC_W-1:0]      adc_s1, adc_s2;
      logic [DAC_W-1:0]      dac;
      logic [ACC_W-1:0]      acc, rxd;
      logic [7:0]            dec_cnt;
      logic                  rx_valid;
      logic                  co_role;
      afl_ctl_t              ctl;
      afl_adr_t              adr;
      logic [DATA_BITS-1:0]  rdata;
      logic                  done;
      logic                  spec_pend, gain_pend, sw_pend;
      afl_ser_t              ser;
      logic [FRAME_BITS-1:0] sh;
      logic [3:0]            cnt;
      logic                  cur_rd;
      logic                  sel_n, sdo;
      afl_act_t              act;
      logic [IRQ_W-1:0]      irq_st, irq_mask;
      logic                  ph_wr;
      logic [7:0]            ph_addr;
      logic [31:0]           hrdata;
   } afl_state_t;

endpackage
`default_nettype wire

// ===== core/afl_link.sv
// Front-end control and data link: sample buses, serial control channel,
// activation sequencer and AHB-Lite register slave.
// Assumes the reference clock pin is slower than half the system clock.
// Functional notes
// - Four-bit transmit bus, moved on reference rise
// - Six-bit receive bus, decimated before echo canceller
// - Select driven low to open each transaction
// - Sixteen bits per transaction, stepped by reference
// - MSB first: address seven, then data eight
// - Direction bit leads on serial output
// - Writes go out, reads come back in
// - Direction and register from address register
// - Front end reached only through three registers
// - Spectrum selection sends configuration word
// - Central office downstream, remote upstream
// - Eight gain codes, plus three to minus eighteen
// - Activation request runs setup without host
// - Role chosen in main configuration register
// - Front end only answers, never initiates
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module afl_link #(
   parameter int DEC_LEN = 16                 // Samples per decimated word
) (
   input  wire logic                        clock,
   input  wire logic                        rst,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic                             hresp,
   output logic [31:0]                      hrdata,
   input  wire logic                        shared_ref_clock,
   input  wire logic [afl_pkg::DAC_W-1:0]   dac_in,
   output logic [afl_pkg::DAC_W-1:0]        dac_out,
   input  wire logic [afl_pkg::ADC_W-1:0]   adc_in,
   output logic [afl_pkg::ACC_W-1:0]        rx_word,
   output logic                             rx_valid,
   output logic                             front_end_select_n,
   output logic                             serial_ctl_out,
   input  wire logic                        serial_ctl_in,
   output logic                             irq
);

   afl_pkg::afl_state_t q;                    // Registered state
   afl_pkg::afl_state_t s;                    // Next state

   logic                 ref_rise;           // Reference clock rose
   logic                 take;               // Engine accepts a request
   logic                 act_req;            // Activation written
   logic                 aphase;             // Bus address phase taken
   afl_pkg::afl_stat_t   stat;               // Status register view

   // Edge of the synchronised reference clock
   assign ref_rise = q.ref_s2 & ~q.ref_s3;
   // Engine starts whenever idle with work queued
   assign take = (q.ser == afl_pkg::SER_IDLE) &&
                 (q.spec_pend | q.gain_pend | q.sw_pend);
   // Activation bit in a main register write
   assign act_req = q.ph_wr && (q.ph_addr == afl_pkg::ADDR_MAIN) &&
                    hwdata[afl_pkg::MAIN_ACT_BIT];
   // AHB-Lite transfer accepted in this cycle
   assign aphase = hsel & hready & htrans[1];
   // Status view of the serial engine
   assign stat = '{done:  q.done,
                   busy:  (q.ser != afl_pkg::SER_IDLE),
                   rdata: q.rdata};

   // Zero-wait slave, always OKAY; hsize ignored, whole words only
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = q.hrdata;
   assign dac_out   = q.dac;
   assign rx_word   = q.rxd;
   assign rx_valid  = q.rx_valid;
   assign front_end_select_n = q.sel_n;
   assign serial_ctl_out     = q.sdo;
   // Level interrupt from unmasked sticky bits
   assign irq = |(q.irq_st & q.irq_mask);

   // Next-state logic of the whole block
   always_comb begin
      logic [afl_pkg::IRQ_W-1:0] irq_set;      // Events this cycle
      logic [afl_pkg::IRQ_W-1:0] irq_clr;      // Cleared by read
      logic                      spec_set;     // Queue spectrum word
      logic                      gain_set;     // Queue gain word
      logic                      sw_set;       // Queue software word
      logic                      spec_tk;      // Spectrum word taken
      logic                      gain_tk;      // Gain word taken
      logic                      sw_tk;        // Software word taken
      logic [afl_pkg::FRAME_BITS-1:0] frame;   // Word to send
      afl_pkg::afl_ctl_t         newc;         // Written control value
      irq_set  = '0;
      irq_clr  = '0;
      spec_set = 1'b0;
      gain_set = 1'b0;
      sw_set   = 1'b0;
      spec_tk  = 1'b0;
      gain_tk  = 1'b0;
      sw_tk    = 1'b0;
      frame    = '0;
      newc     = q.ctl;
      s        = q;
      s.rx_valid = 1'b0;

      // Two-flop synchronisers on all pins from the front end
      s.ref_s1 = shared_ref_clock;
      s.ref_s2 = q.ref_s1;
      s.ref_s3 = q.ref_s2;
      s.in_s1  = serial_ctl_in;
      s.in_s2  = q.in_s1;
      s.adc_s1 = adc_in;
      s.adc_s2 = q.adc_s1;

      // Transmit word handed over on reference rise
      if (ref_rise) begin
         s.dac = dac_in;
      end

      // Decimator: sum DEC_LEN receive samples into one word
      if (ref_rise) begin
         if (q.dec_cnt == 8'(DEC_LEN - 1)) begin
            s.rxd      = q.acc + afl_pkg::ACC_W'(q.adc_s2);
            s.acc      = '0;
            s.dec_cnt  = '0;
            s.rx_valid = 1'b1;
         end else begin
            s.acc     = q.acc + afl_pkg::ACC_W'(q.adc_s2);
            s.dec_cnt = q.dec_cnt + 8'h01;
         end
      end

      // Bus address phase: latch control, build read data
      s.ph_wr   = aphase & hwrite;
      s.ph_addr = haddr[7:0];
      if (aphase && !hwrite) begin
         s.hrdata = '0;
         unique case (haddr[7:0])
            afl_pkg::ADDR_MAIN:
               s.hrdata[afl_pkg::MAIN_ROLE_BIT] = q.co_role;
            afl_pkg::ADDR_CTL:
               s.hrdata[afl_pkg::CTL_W-1:0] = q.ctl;
            afl_pkg::ADDR_ADR:
               s.hrdata[afl_pkg::ADR_W-1:0] = q.adr;
            afl_pkg::ADDR_STAT:
               s.hrdata[$bits(stat)-1:0] = stat;
            afl_pkg::ADDR_IRQ: begin
               s.hrdata[afl_pkg::IRQ_W-1:0] = q.irq_st;
               irq_clr = '1;                              // Read clears
            end
            afl_pkg::ADDR_MASK:
               s.hrdata[afl_pkg::IRQ_W-1:0] = q.irq_mask;
            afl_pkg::ADDR_RXD:
               s.hrdata[afl_pkg::ACC_W-1:0] = q.rxd;
            default:
               s.hrdata = '0;                             // Unmapped
         endcase
      end

      // Bus data phase: apply writes
      if (q.ph_wr) begin
         unique case (q.ph_addr)
            afl_pkg::ADDR_MAIN:
               s.co_role = hwdata[afl_pkg::MAIN_ROLE_BIT];
            afl_pkg::ADDR_CTL: begin
               newc     = afl_pkg::afl_ctl_t'(hwdata[afl_pkg::CTL_W-1:0]);
               spec_set = newc.spec_dn != q.ctl.spec_dn;
               gain_set = newc.gain != q.ctl.gain;
               s.ctl    = newc;
            end
            afl_pkg::ADDR_ADR: begin
               s.adr  = afl_pkg::afl_adr_t'(hwdata[afl_pkg::ADR_W-1:0]);
               sw_set = 1'b1;
            end
            afl_pkg::ADDR_MASK:
               s.irq_mask = hwdata[afl_pkg::IRQ_W-1:0];
            default: ;                                    // Ignored
         endcase
      end

      // Activation sequencer
      unique case (q.act)
         afl_pkg::ACT_IDLE: begin
            if (act_req) begin
               // Role picks the spectrum, then gain follows
               s.ctl.spec_dn = s.co_role;
               spec_set      = 1'b1;
               gain_set      = 1'b1;
               s.act         = afl_pkg::ACT_RUN;
            end
         end
         afl_pkg::ACT_RUN: begin
            // Finished once both words are out and the engine rests
            if (!q.spec_pend && !q.gain_pend && !take &&
                q.ser == afl_pkg::SER_IDLE) begin
               irq_set[afl_pkg::IRQ_ACT] = 1'b1;
               s.act = afl_pkg::ACT_IDLE;
            end
         end
      endcase

      // Request selection: spectrum, then gain, then software
      if (q.spec_pend) begin
         spec_tk = take;
         frame   = {~afl_pkg::RW_READ, afl_pkg::FE_SPEC_REG,
                    q.ctl.spec_dn ? afl_pkg::SPEC_DN_VAL
                                  : afl_pkg::SPEC_UP_VAL};
      end else if (q.gain_pend) begin
         gain_tk = take;
         frame   = {~afl_pkg::RW_READ, afl_pkg::FE_GAIN_REG,
                    (afl_pkg::DATA_BITS - afl_pkg::GAIN_W)'(0),
                    q.ctl.gain};
      end else begin
         sw_tk = take;
         frame = {q.adr.rd, q.adr.addr, q.ctl.wdata};
      end

      // Serial control engine
      unique case (q.ser)
         afl_pkg::SER_IDLE: begin
            if (take) begin
               s.sh     = frame;
               s.cur_rd = sw_tk && (q.adr.rd == afl_pkg::RW_READ);
               s.done   = 1'b0;
               s.ser    = afl_pkg::SER_ARM;
            end
         end
         afl_pkg::SER_ARM: begin
            // Open the frame on a reference rise
            if (ref_rise) begin
               s.sel_n = 1'b0;
               s.sdo   = q.sh[afl_pkg::FRAME_BITS-1];
               s.cnt   = '0;
               s.ser   = afl_pkg::SER_SHIFT;
            end
         end
         afl_pkg::SER_SHIFT: begin
            if (ref_rise) begin
               // Sample input at the end of each bit period
               s.sh = {q.sh[afl_pkg::FRAME_BITS-2:0], q.in_s2};
               if (q.cnt == afl_pkg::LAST_BIT) begin
                  s.sel_n = 1'b1;
                  s.sdo   = 1'b0;
                  s.done  = 1'b1;
                  irq_set[afl_pkg::IRQ_XFER] = 1'b1;
                  if (q.cur_rd) begin
                     s.rdata = {q.sh[afl_pkg::DATA_BITS-2:0],
                                q.in_s2};
                  end
                  s.ser = afl_pkg::SER_IDLE;
               end else begin
                  s.cnt = q.cnt + 4'h1;
                  s.sdo = q.sh[afl_pkg::FRAME_BITS-2];
               end
            end
         end
      endcase

      // Queues and sticky bits: a new event beats its clear
      s.spec_pend = spec_set | (q.spec_pend & ~spec_tk);
      s.gain_pend = gain_set | (q.gain_pend & ~gain_tk);
      s.sw_pend   = sw_set | (q.sw_pend & ~sw_tk);
      s.irq_st    = irq_set | (q.irq_st & ~irq_clr);
   end

   // State register with synchronous reset
   always_ff @(posedge clock) begin
      if (rst) begin
         q       <= '0;
         q.ser   <= afl_pkg::SER_IDLE;
         q.act   <= afl_pkg::ACT_IDLE;
         q.sel_n <= 1'b1;
      end else begin
         q <= s;
      end
   end

   // Checks on the serial channel and link buses
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence frame_open;
      $fell(front_end_select_n);
   endsequence

   sequence frame_close;
      $rose(front_end_select_n);
   endsequence

   sequence last_bit_edge;
      (q.ser == afl_pkg::SER_SHIFT) && ref_rise &&
      (q.cnt == afl_pkg::LAST_BIT);
   endsequence

   sel_window_a: assert property (
      (q.ser == afl_pkg::SER_SHIFT) == !front_end_select_n)
      else $error("select low outside shift state");

   bit_count_a: assert property (
      frame_close |-> $past(q.cnt) == afl_pkg::LAST_BIT)
      else $error("frame did not carry sixteen bits");

   rw_first_a: assert property (
      frame_open |-> serial_ctl_out == $past(q.sh[afl_pkg::FRAME_BITS-1]))
      else $error("direction bit not first on serial out");

   msb_order_a: assert property (
      ((q.ser == afl_pkg::SER_SHIFT) && ref_rise &&
       (q.cnt != afl_pkg::LAST_BIT))
      |=> serial_ctl_out == $past(q.sh[afl_pkg::FRAME_BITS-2]))
      else $error("serial bits not shifted msb first");

   serial_step_a: assert property (
      $changed(serial_ctl_out) |-> $past(ref_rise))
      else $error("serial out moved without reference rise");

   dac_step_a: assert property (
      $changed(dac_out) |-> $past(ref_rise))
      else $error("transmit bus moved without reference rise");

   rd_capture_a: assert property (
      (last_bit_edge ##0 q.cur_rd)
      |=> stat.rdata == $past({q.sh[afl_pkg::DATA_BITS-2:0], q.in_s2}))
      else $error("read byte not captured into status");

   done_flag_a: assert property (
      last_bit_edge |=> front_end_select_n && stat.done &&
                        q.irq_st[afl_pkg::IRQ_XFER])
      else $error("transfer end not flagged");

   role_spec_a: assert property (
      ((q.act == afl_pkg::ACT_IDLE) && act_req)
      |=> q.spec_pend && (q.ctl.spec_dn == q.co_role))
      else $error("activation spectrum does not follow role");

   // Software words carry the address register and write byte
   sw_frame_a: assert property (
      (take && !q.spec_pend && !q.gain_pend)
      |=> q.sh == $past({q.adr.rd, q.adr.addr, q.ctl.wdata}))
      else $error("software word not built from address register");

   // Gain words address the gain register and carry the code
   gain_frame_a: assert property (
      (take && !q.spec_pend && q.gain_pend)
      |=> (q.sh[afl_pkg::FRAME_BITS-2 -: afl_pkg::ADDR_BITS] ==
           afl_pkg::FE_GAIN_REG) &&
          (q.sh[afl_pkg::GAIN_W-1:0] == $past(q.ctl.gain)))
      else $error("gain word malformed");

   // Spectrum words carry the filter value of the control register
   spec_frame_a: assert property (
      (take && q.spec_pend)
      |=> q.sh[afl_pkg::DATA_BITS-1:0] == ($past(q.ctl.spec_dn) ?
          afl_pkg::SPEC_DN_VAL : afl_pkg::SPEC_UP_VAL))
      else $error("spectrum word carries wrong filter value");

   // Serial out stays quiet while the front end is deselected
   idle_line_a: assert property (
      front_end_select_n |-> !serial_ctl_out)
      else $error("serial out not quiet between frames");

   // Decimated word strobe lasts a single cycle
   rx_pulse_a: assert property (
      rx_valid |=> !rx_valid)
      else $error("receive word strobe longer than one cycle");

endmodule
`default_nettype wire

// ===== test/afl_fe_model.sv
// Behavioural front end: reference clock source and serial register slave.
// Assumes the link samples its pins on rises of the reference clock.
`timescale 1ns/1ns
`default_nettype none
module afl_fe_model (
   output logic            shared_ref_clock,
   input  wire logic       front_end_select_n,
   input  wire logic       serial_ctl_out,
   output logic            serial_ctl_in,
   input  wire logic [3:0] dac_out,
   output logic [5:0]      adc_in,
   input  wire logic [5:0] adc_val,
   output logic [15:0]     last_word,
   output logic [15:0]     frames,
   output logic [3:0]      last_dac,
   output logic            bad_len
);
   logic        xtal;       // Local crystal
   logic [7:0]  regs [128]; // Register file
   logic [15:0] sh;         // Incoming word
   logic [7:0]  rd_b;       // Byte returned on a read
   logic        rd_act;     // Current frame is a read
   int          n;          // Bits taken this frame
   initial begin
      xtal = 1'h0;
      shared_ref_clock = 1'h0;
      serial_ctl_in = 1'h0;
      adc_in = 6'h00;
      {sh, rd_b, rd_act, n, last_word, frames, last_dac, bad_len} = '0;
      foreach (regs[i]) regs[i] = 8'h00;
   end
   // Crystal, 80 ns period, edges on falling edges of the system clock
   always #40 xtal = ~xtal;
   // Reference is the crystal halved
   always @(posedge xtal) shared_ref_clock <= ~shared_ref_clock;
   // Take one bit per rise while selected; never starts a frame itself
   always @(posedge shared_ref_clock) begin
      last_dac <= dac_out;
      if (!front_end_select_n) begin
         sh = {sh[14:0], serial_ctl_out};
         n = n + 1;
         if (n == 8) begin
            rd_act = sh[7];
            rd_b = regs[sh[6:0]];
         end
         if (n == 16) begin
            last_word <= sh;
            frames <= frames + 16'h1;
            if (!sh[15]) regs[sh[14:8]] = sh[7:0];
         end
      end else begin
         // A frame must span exactly sixteen rises
         if (n != 0 && n != 16) bad_len <= 1'h1;
         n = 0;
      end
   end
   // Read bits and samples change mid-period, away from the rise
   always @(negedge shared_ref_clock) begin
      adc_in <= adc_val;
      if (!front_end_select_n && rd_act && n >= 8 && n < 16)
         serial_ctl_in <= rd_b[3'(15 - n)];
      else
         serial_ctl_in <= ~serial_ctl_in;
   end
endmodule
`default_nettype wire

// ===== test/test_afe_control_and_data_link.sv
// Self-checking bench for the front-end link block.
// Assumes the front-end model supplies the reference clock and read data.
`timescale 1ns/1ns
`default_nettype none
module test_afe_control_and_data_link;
   localparam int DEC = 4;           // Short decimation for simulation
   logic        clock = 1'h0;        // System clock
   logic        rst = 1'h1;          // Synchronous reset
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rdv;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0, hready, hresp, irq, rx_valid;
   logic        shared_ref_clock, front_end_select_n;
   logic        serial_ctl_out, serial_ctl_in, bad_len;
   logic [3:0]  dac_in = 4'h0, dac_out, last_dac;
   logic [5:0]  adc_in, adc_val = 6'h00;
   logic [15:0] rx_word, last_word, frames;
   int          miscompares = 0, compares = 0, cyc = 0;
   // Rows: {dir,reg}, data, expected read byte
   logic [23:0] rows [6] = '{24'h053C00, 24'h85003C, 24'h7FFF00,
                             24'hFF00FF, 24'h800000, 24'h408100};

   afl_link #(.DEC_LEN(DEC)) dut_u (.clock(clock), .rst(rst), .hsel(1'h1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .shared_ref_clock(shared_ref_clock),
      .dac_in(dac_in), .dac_out(dac_out), .adc_in(adc_in),
      .rx_word(rx_word), .rx_valid(rx_valid),
      .front_end_select_n(front_end_select_n),
      .serial_ctl_out(serial_ctl_out), .serial_ctl_in(serial_ctl_in),
      .irq(irq));
   afl_fe_model fe_u (.shared_ref_clock(shared_ref_clock),
      .front_end_select_n(front_end_select_n),
      .serial_ctl_out(serial_ctl_out), .serial_ctl_in(serial_ctl_in),
      .dac_out(dac_out), .adc_in(adc_in), .adc_val(adc_val),
      .last_word(last_word), .frames(frames), .last_dac(last_dac),
      .bad_len(bad_len));

   always #10 clock = ~clock;

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Single write: address phase, then data phase
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= 1'h1;
      do @(posedge clock); while (hready !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'h1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= 1'h0;
      do @(posedge clock); while (hready !== 1'h1);
      htrans <= 2'h0;
      do @(posedge clock); while (hready !== 1'h1);
      d = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, string nm);
      logic [31:0] d;
      rd(a, d);
      chk(nm, e, d);
   endtask
   // Wait for n more frames, then for status to show done
   task automatic wait_fr(input int n);
      logic [15:0] t;
      t = frames + 16'(n);
      for (int i = 0; i < 4000 && frames != t; i++) @(posedge clock);
      for (int i = 0; i < 40; i++) begin
         rd(afl_pkg::ADDR_STAT, rdv);
         if (rdv[9:8] == 2'h2) break;
      end
      chk("frames", {16'h0, t}, {16'h0, frames});
      chk("stat done", 32'h2, {30'h0, rdv[9:8]});
   endtask

   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'h0;
      chk("select", 32'h1, {31'h0, front_end_select_n});
      chk("sdo idle", 32'h0, {31'h0, serial_ctl_out});
      chk("irq", 32'h0, {31'h0, irq});
      chk("hresp", 32'h0, {31'h0, hresp});
      for (int a = 0; a < 32; a += 4) rchk(8'(a), 32'h0, "reset reg");
      wr(afl_pkg::ADDR_STAT, 32'hFFFFFFFF);
      wr(8'h1C, 32'hFFFFFFFF);
      rchk(afl_pkg::ADDR_STAT, 32'h0, "read-only stat");
      rchk(8'h1C, 32'h0, "unmapped");
      // Software transfers, one row each
      foreach (rows[i]) begin
         wr(afl_pkg::ADDR_CTL, {24'h0, rows[i][15:8]});
         wr(afl_pkg::ADDR_ADR, {24'h0, rows[i][23:16]});
         wait_fr(1);
         chk("word", {16'h0, rows[i][23:8]}, {16'h0, last_word});
         if (rows[i][23])
            chk("read byte", {24'h0, rows[i][7:0]}, {24'h0, rdv[7:0]});
      end
      // Interrupt masked, then raised and cleared by reads
      chk("irq masked", 32'h0, {31'h0, irq});
      rchk(afl_pkg::ADDR_IRQ, 32'h1, "irq status");
      rchk(afl_pkg::ADDR_IRQ, 32'h0, "irq cleared");
      wr(afl_pkg::ADDR_MASK, 32'h3);
      rchk(afl_pkg::ADDR_MASK, 32'h3, "mask");
      wr(afl_pkg::ADDR_ADR, 32'h05);
      wait_fr(1);
      chk("irq raised", 32'h1, {31'h0, irq});
      rchk(afl_pkg::ADDR_IRQ, 32'h1, "irq status");
      rchk(afl_pkg::ADDR_IRQ, 32'h0, "irq cleared");
      chk("irq low", 32'h0, {31'h0, irq});
      // Every gain code sends one word
      for (int k = 1; k <= 8; k++) begin
         wr(afl_pkg::ADDR_CTL, {20'h0, 3'(k), 9'h0});
         wait_fr(1);
         chk("gain word", {17'h0, afl_pkg::FE_GAIN_REG, 5'h0, 3'(k)},
             {16'h0, last_word});
      end
      wr(afl_pkg::ADDR_CTL, 32'h100);
      wait_fr(1);
      chk("spec word", {17'h0, afl_pkg::FE_SPEC_REG, afl_pkg::SPEC_DN_VAL},
          {16'h0, last_word});
      // Activation as remote, then as central office
      for (int r = 0; r < 2; r++) begin
         rd(afl_pkg::ADDR_IRQ, rdv);
         wr(afl_pkg::ADDR_MAIN, {30'h0, 1'h1, 1'(r)});
         wait_fr(2);
         chk("spectrum", {24'h0, (r == 1) ? afl_pkg::SPEC_DN_VAL :
             afl_pkg::SPEC_UP_VAL}, {24'h0, fe_u.regs[1]});
         rchk(afl_pkg::ADDR_CTL, {23'h0, 1'(r), 8'h0}, "ctl spec");
         rchk(afl_pkg::ADDR_MAIN, {31'h0, 1'(r)}, "main");
         rchk(afl_pkg::ADDR_IRQ, 32'h3, "act irq");
      end
      // Sample buses
      adc_val <= 6'h2B;
      dac_in <= 4'hA;
      repeat (3) begin
         @(posedge clock);
         for (int i = 0; i < 400 && rx_valid !== 1'h1; i++) @(posedge clock);
      end
      chk("rx valid", 32'h1, {31'h0, rx_valid});
      chk("rx word", 32'(DEC) * 32'h2B, {16'h0, rx_word});
      rchk(afl_pkg::ADDR_RXD, 32'(DEC) * 32'h2B, "rxd");
      chk("dac out", 32'hA, {28'h0, dac_out});
      chk("dac at front end", 32'hA, {28'h0, last_dac});
      chk("frame length", 32'h0, {31'h0, bad_len});
      conclude();
   end
endmodule
`default_nettype wire
